// file: verilog/timer_defs.svh
// register offsets, field positions and reset values of the 16-bit timer block
// assumes byte-wide cpu bus access and a single 100 MHz clock domain
//
// Overview of operation
// - Writing a compare shadow sets that channel's compare buffer-valid bit.
// - Writing the period shadow sets the period buffer-valid bit.
// - An update condition clears every buffer-valid bit.
// - Alias write: one sets buffer-valid bit, zero leaves it; compare 2..0 bits 3..1.
// - Action 0 counts rising event edges, action 1 counts both edges.
// - Action 2 counts prescaled ticks only while the event is high.
// - Action 3 counts ticks, up while event low, down while high.
// - Event actions apply only when the event-count enable bit 0 is set.
// - Interrupt enable bits 4..6 allow compare channel 0..2 requests.
// - Interrupt enable bit 0 allows the wrap request.
// - Compare flag n sets whenever the counter equals compare register n.
// - Compare flags stay set until software writes one to them.
// - Wrap flag sets at top or bottom as the waveform mode selects.
// - Wrap flag stays set until software writes one to bit 0.
// - Halted cpu with run-while-halted clear stops the timer and its events.
// - One shared readable and writable temporary byte serves all wide registers.
// - Wide registers hold the low byte at offset, high byte at offset plus one.
// - A bus write to the counter wins over a same-cycle count update.
// - Period register is top in every mode except frequency waveform.
// - An update condition copies each compare shadow into its compare register.
// - Lock-transfer set suppresses shadow transfers, so valid bits persist.
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFS_BV_SET 8'h07
`define OFS_EVENT_CONTROL 8'h09
`define OFS_INT_ENABLE 8'h0a
`define OFS_INT_FLAGS 8'h0b
`define OFS_DEBUG_RUN 8'h0e
`define OFS_WIDE_LATCH 8'h0f
`define OFS_COUNTER 8'h20
`define OFS_PERIOD 8'h26
`define OFS_COMPARE0 8'h28
`define OFS_PERIOD_SHADOW 8'h36
`define OFS_COMPARE0_SHADOW 8'h38
`define OFS_HIGH_BYTE 8'h01
`define OFS_CHANNEL_STEP 8'h02

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_PERIOD_BV 0
`define BIT_COMPARE0_BV 1
`define BIT_EVENT_COUNT_EN 0
`define BIT_EVENT_ACTION_LO 1
`define BIT_WRAP 0
`define BIT_COMPARE0_FLAG 4
`define BIT_RUN_WHILE_HALTED 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_COUNTER 16'h0000
`define RST_PERIOD 16'hffff
`define RST_COMPARE 16'h0000

`endif

// file: verilog/timer_pkg.sv
// types shared by the timer register block and its event front end
// assumes the constants header is included where offsets are needed
package timer_pkg;

    typedef enum logic [1:0] {
        COUNT_RISING_EDGES = 2'b00,
        COUNT_BOTH_EDGES = 2'b01,
        COUNT_WHILE_HIGH = 2'b10,
        EVENT_SETS_DIRECTION = 2'b11
    } event_action_e;

    typedef enum logic [2:0] {
        WAVE_NORMAL = 3'b000,
        FREQUENCY_WAVEFORM = 3'b001,
        WAVE_SINGLE_SLOPE = 3'b011,
        WAVE_DUAL_TOP = 3'b101,
        WAVE_DUAL_BOTH = 3'b110,
        WAVE_DUAL_BOTTOM = 3'b111
    } waveform_mode_e;

    // state of the event front end
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic step;
        logic down;
    } shaper_s;

    // state of the register block
    typedef struct packed {
        logic [3:0] buffer_valid;
        logic [3:0] event_control;
        logic [3:0] interrupt_enable;
        logic [3:0] interrupt_flags;
        logic run_while_halted;
        logic [7:0] wide_access_latch;
        logic [15:0] counter_value;
        logic [15:0] period_top;
        logic [15:0] period_shadow;
        logic [2:0][15:0] compare_value;
        logic [2:0][15:0] compare_shadow;
        logic [7:0] rdata;
        logic [2:0] irq_compare;
        logic irq_wrap;
    } timer_s;

endpackage : timer_pkg

// file: verilog/count_ctl_if.sv
// control and count-step signals between the register block and the event front end
// assumes both ends sit on the same clock
interface count_ctl_if;
    logic [1:0] action;
    logic enable;
    logic allow;
    logic tick;
    logic dir;
    logic step;
    logic down;

    modport regs (output action, enable, allow, tick, dir, input step, down);
    modport shaper (input action, enable, allow, tick, dir, output step, down);
endinterface : count_ctl_if

// file: verilog/event_shaper.sv
// event input synchroniser and count-step decoder
// assumes the event arrives from outside the clock domain
module event_shaper
    import timer_pkg::*;
(
    input wire logic i_mclk, // system clock
    input wire logic i_nrst, // synchronous reset, active low
    input wire logic i_event, // raw event level
    count_ctl_if.shaper ctl // control in, step out
);

    shaper_s q;
    shaper_s d;
    logic rise;
    logic any_edge;

    // edge detect looks only past the second sync stage
    always_comb begin
        d = q;
        d.sync1 = i_event;
        d.sync2 = q.sync1;
        d.prev = q.sync2;
        rise = q.sync2 & ~q.prev;
        any_edge = q.sync2 ^ q.prev;
        d.step = 1'b0;
        d.down = ctl.dir;
        if (!ctl.allow) begin
            d.step = 1'b0;
        end else if (!ctl.enable) begin
            d.step = ctl.tick;
        end else begin
            unique case (event_action_e'(ctl.action))
                COUNT_RISING_EDGES: d.step = rise;
                COUNT_BOTH_EDGES: d.step = any_edge;
                COUNT_WHILE_HIGH: d.step = ctl.tick & q.sync2;
                EVENT_SETS_DIRECTION: begin
                    d.step = ctl.tick;
                    d.down = q.sync2;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ctl.step = q.step;
    assign ctl.down = q.down;

endmodule // event_shaper

// file: verilog/timer_regs.sv
// 16-bit timer register block: buffers, event counting, flags and wide access
// assumes a byte cpu bus on the same clock; prescaled tick comes from the clock block
`include "timer_defs.svh"

module timer_regs
    import timer_pkg::*;
(
    input wire logic i_mclk, // system clock, 100 MHz
    input wire logic i_nrst, // synchronous reset, active low
    input wire logic [7:0] i_addr, // register byte offset
    input wire logic i_wr, // write strobe, one cycle
    input wire logic i_rd, // read strobe, one cycle
    input wire logic [7:0] i_wdata, // write data
    input wire logic i_tick, // prescaled clock tick, one cycle
    input wire logic i_run, // timer enabled
    input wire logic i_dir_down, // software count direction
    input wire logic [2:0] i_waveform_mode_select, // waveform mode
    input wire logic i_lock_transfer, // suppress shadow transfers
    input wire logic i_cpu_halted, // cpu in debug break
    input wire logic i_event, // event input, asynchronous
    output logic [7:0] o_rdata, // read data, one cycle after i_rd
    output logic [2:0] o_irq_compare, // compare requests, channel 0..2
    output logic o_irq_wrap // wrap request
);

    timer_s q;
    timer_s d;
    count_ctl_if ctl ();

    // ------------------------------------------------------------------
    // event front end
    // ------------------------------------------------------------------
    event_shaper u_shaper (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_event(i_event),
        .ctl(ctl)
    );

    // control toward the front end comes from flops and input ports, no combinational loop
    assign ctl.action = q.event_control[2:1];
    assign ctl.enable = q.event_control[`BIT_EVENT_COUNT_EN];
    assign ctl.allow = i_run & (q.run_while_halted | ~i_cpu_halted);
    assign ctl.tick = i_tick;
    assign ctl.dir = i_dir_down;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // 2'b01 low byte hit, 2'b10 high byte hit, else no hit
    function automatic logic [1:0] wide_hit(input logic [7:0] addr, input logic [7:0] base);
        wide_hit = {addr == (base + `OFS_HIGH_BYTE), addr == base};
    endfunction

    function automatic logic [7:0] chan_base(input logic [7:0] base, input int n);
        chan_base = base + 8'(n) * `OFS_CHANNEL_STEP;
    endfunction

    logic [15:0] top_value;
    logic top_hit;
    logic bottom_hit;
    logic wrap_now;
    logic update_now;
    logic [1:0] hit;
    logic [15:0] wide_word;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        top_hit = 1'b0;
        bottom_hit = 1'b0;
        hit = 2'b00;
        wide_word = {i_wdata, q.wide_access_latch};
        // frequency mode takes top from compare 0
        if (waveform_mode_e'(i_waveform_mode_select) == FREQUENCY_WAVEFORM) begin
            top_value = q.compare_value[0];
        end else begin
            top_value = q.period_top;
        end

        // counting; bus writes below override this
        if (ctl.step) begin
            if (ctl.down) begin
                if (q.counter_value == 16'h0000) begin
                    d.counter_value = top_value;
                    bottom_hit = 1'b1;
                end else begin
                    d.counter_value = q.counter_value - 16'h0001;
                end
            end else begin
                if (q.counter_value == top_value) begin
                    d.counter_value = 16'h0000;
                    top_hit = 1'b1;
                end else begin
                    d.counter_value = q.counter_value + 16'h0001;
                end
            end
        end

        // wrap and update points follow the waveform mode
        unique case (i_waveform_mode_select)
            3'b000, 3'b001: begin
                wrap_now = top_hit;
                update_now = top_hit;
            end
            3'b101: begin
                wrap_now = top_hit;
                update_now = bottom_hit;
            end
            3'b110: begin
                wrap_now = top_hit | bottom_hit;
                update_now = bottom_hit;
            end
            default: begin
                wrap_now = bottom_hit;
                update_now = bottom_hit;
            end
        endcase

        // shadow transfer on update unless locked
        if (update_now && !i_lock_transfer) begin
            d.period_top = q.period_shadow;
            d.compare_value = q.compare_shadow;
            d.buffer_valid = 4'h0;
        end

        // software clears first so hardware sets win in the same cycle
        if (i_wr && i_addr == `OFS_INT_FLAGS) begin
            d.interrupt_flags = q.interrupt_flags & ~{i_wdata[6:4], i_wdata[`BIT_WRAP]};
        end
        for (int n = 0; n < 3; n++) begin
            if (q.counter_value == q.compare_value[n]) begin
                d.interrupt_flags[n + 1] = 1'b1;
            end
        end
        if (wrap_now) begin
            d.interrupt_flags[0] = 1'b1;
        end

        // bus writes
        if (i_wr) begin
            unique case (i_addr)
                `OFS_BV_SET: d.buffer_valid = d.buffer_valid | i_wdata[3:0];
                `OFS_EVENT_CONTROL: d.event_control = i_wdata[3:0];
                `OFS_INT_ENABLE: d.interrupt_enable = {i_wdata[6:4], i_wdata[`BIT_WRAP]};
                `OFS_DEBUG_RUN: d.run_while_halted = i_wdata[`BIT_RUN_WHILE_HALTED];
                `OFS_WIDE_LATCH: d.wide_access_latch = i_wdata;
                default: ;
            endcase
            // low byte writes park in the latch, high byte writes commit
            hit = wide_hit(i_addr, `OFS_COUNTER) | wide_hit(i_addr, `OFS_PERIOD)
                | wide_hit(i_addr, `OFS_PERIOD_SHADOW);
            for (int n = 0; n < 3; n++) begin
                hit = hit | wide_hit(i_addr, chan_base(`OFS_COMPARE0, n))
                    | wide_hit(i_addr, chan_base(`OFS_COMPARE0_SHADOW, n));
            end
            if (hit[0]) begin
                d.wide_access_latch = i_wdata;
            end
            if (wide_hit(i_addr, `OFS_COUNTER) == 2'b10) begin
                d.counter_value = wide_word;
            end
            if (wide_hit(i_addr, `OFS_PERIOD) == 2'b10) begin
                d.period_top = wide_word;
            end
            if (wide_hit(i_addr, `OFS_PERIOD_SHADOW) == 2'b10) begin
                d.period_shadow = wide_word;
                d.buffer_valid[`BIT_PERIOD_BV] = 1'b1;
            end
            for (int n = 0; n < 3; n++) begin
                if (wide_hit(i_addr, chan_base(`OFS_COMPARE0, n)) == 2'b10) begin
                    d.compare_value[n] = wide_word;
                end
                if (wide_hit(i_addr, chan_base(`OFS_COMPARE0_SHADOW, n)) == 2'b10) begin
                    d.compare_shadow[n] = wide_word;
                    d.buffer_valid[n + 1] = 1'b1;
                end
            end
        end

        // reads: low byte returns now and latches high byte for later
        d.rdata = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                `OFS_BV_SET: d.rdata = {4'h0, q.buffer_valid};
                `OFS_EVENT_CONTROL: d.rdata = {4'h0, q.event_control};
                `OFS_INT_ENABLE: d.rdata = {1'b0, q.interrupt_enable[3:1], 3'b000,
                    q.interrupt_enable[0]};
                `OFS_INT_FLAGS: d.rdata = {1'b0, q.interrupt_flags[3:1], 3'b000,
                    q.interrupt_flags[0]};
                `OFS_DEBUG_RUN: d.rdata = {7'h00, q.run_while_halted};
                `OFS_WIDE_LATCH: d.rdata = q.wide_access_latch;
                default: ;
            endcase
            read_wide(`OFS_COUNTER, q.counter_value);
            read_wide(`OFS_PERIOD, q.period_top);
            read_wide(`OFS_PERIOD_SHADOW, q.period_shadow);
            for (int n = 0; n < 3; n++) begin
                read_wide(chan_base(`OFS_COMPARE0, n), q.compare_value[n]);
                read_wide(chan_base(`OFS_COMPARE0_SHADOW, n), q.compare_shadow[n]);
            end
        end

        // requests are flags gated by their enables
        d.irq_compare = d.interrupt_flags[3:1] & d.interrupt_enable[3:1];
        d.irq_wrap = d.interrupt_flags[0] & d.interrupt_enable[0];
    end

    // low read hands back the low byte and parks the high byte; high read returns the latch
    function automatic void read_wide(input logic [7:0] base, input logic [15:0] value);
        if (i_addr == base) begin
            d.rdata = value[7:0];
            d.wide_access_latch = value[15:8];
        end else if (i_addr == base + `OFS_HIGH_BYTE) begin
            d.rdata = q.wide_access_latch;
        end
    endfunction

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            q.buffer_valid <= 4'h0;
            q.event_control <= 4'h0;
            q.interrupt_enable <= 4'h0;
            q.interrupt_flags <= 4'h0;
            q.run_while_halted <= 1'b0;
            q.wide_access_latch <= `RST_BYTE;
            q.counter_value <= `RST_COUNTER;
            q.period_top <= `RST_PERIOD;
            q.period_shadow <= `RST_PERIOD;
            q.compare_value <= {3{`RST_COMPARE}};
            q.compare_shadow <= {3{`RST_COMPARE}};
            q.rdata <= `RST_BYTE;
            q.irq_compare <= 3'b000;
            q.irq_wrap <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign o_rdata = q.rdata;
    assign o_irq_compare = q.irq_compare;
    assign o_irq_wrap = q.irq_wrap;

endmodule // timer_regs

// file: verilog/timer_regs_tail.sv
// no logic lives in this file

// file: testbench/cpu_bus_model.sv
// byte-wide cpu bus master standing in for the processor and debug port
// assumes one-cycle strobes sampled on the rising edge of the shared clock
module cpu_bus_model (
    input wire logic i_mclk, // system clock
    input wire logic [7:0] i_rdata, // read data from the timer
    output logic [7:0] o_addr, // register byte offset
    output logic o_wr, // write strobe
    output logic o_rd, // read strobe
    output logic [7:0] o_wdata // write data
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------------
    // byte and wide transfers
    // ----------------------------------------------------------------------
    // idle bus: no strobes, address parked on an unmapped offset
    initial begin
        o_addr = 8'hff;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 8'h00;
    end

    // data goes inverted after release so a stale byte never looks valid
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_mclk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask

    // read data is taken one cycle after the strobe, before it drops to zero
    task automatic rd8(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_mclk);
        o_rd <= 1'b0;
        @(posedge i_mclk);
        d = i_rdata;
    endtask

    // low byte first, the low byte travels through the shared latch
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr8(a, v[7:0]);
        wr8(a + 8'h01, v[15:8]);
    endtask

    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        rd8(a, v[7:0]);
        rd8(a + 8'h01, v[15:8]);
    endtask
endmodule // cpu_bus_model

// file: testbench/timer_regs_properties.sv
// port-level checks of the timer register block
// assumes one clock domain and a synchronous active-low reset
module timer_regs_checker (
    input wire logic i_mclk, // system clock
    input wire logic i_nrst, // synchronous reset, active low
    input wire logic [7:0] i_addr, // register byte offset
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    input wire logic [7:0] i_wdata, // write data
    input wire logic [7:0] o_rdata, // read data
    input wire logic [2:0] o_irq_compare, // compare requests
    input wire logic o_irq_wrap // wrap request
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------------
    // enable mirror and properties
    // ----------------------------------------------------------------------
    logic [7:0] ien_q;
    logic [7:0] ien_d;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);

    // mirror enable writes so request gating can be judged from the ports
    always_comb begin
        ien_d = ien_q;
        if (i_wr && i_addr == 8'h0a) begin
            ien_d = i_wdata & 8'h71;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            ien_q <= 8'h00;
        end else begin
            ien_q <= ien_d;
        end
    end

    property p_rdata_idle;
        !$past(i_rd) |-> o_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not idle");

    property p_unmapped;
        $past(i_rd) && $past(i_addr) == 8'h10 |-> o_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_alias_rsvd;
        $past(i_rd) && $past(i_addr) == 8'h07 |-> o_rdata[7:4] == 4'h0;
    endproperty
    a_alias_rsvd: assert property (p_alias_rsvd)
        else $error("valid byte upper bits set");

    property p_flag_rsvd;
        $past(i_rd) && $past(i_addr) == 8'h0b |-> (o_rdata & 8'h8e) == 8'h00;
    endproperty
    a_flag_rsvd: assert property (p_flag_rsvd)
        else $error("flag byte reserved bits set");

    property p_enable_read;
        $past(i_rd) && $past(i_addr) == 8'h0a |-> o_rdata == $past(ien_q);
    endproperty
    a_enable_read: assert property (p_enable_read)
        else $error("enable byte readback wrong");

    property p_cmp_gate;
        (o_irq_compare & ~$past(o_irq_compare) & ~ien_q[6:4]) == 3'b000;
    endproperty
    a_cmp_gate: assert property (p_cmp_gate)
        else $error("compare request without enable");

    property p_wrap_gate;
        $rose(o_irq_wrap) |-> ien_q[0];
    endproperty
    a_wrap_gate: assert property (p_wrap_gate)
        else $error("wrap request without enable");

    property p_wrap_sticky;
        $fell(o_irq_wrap) |-> $past(i_wr && ((i_addr == 8'h0b && i_wdata[0])
            || (i_addr == 8'h0a && !i_wdata[0])));
    endproperty
    a_wrap_sticky: assert property (p_wrap_sticky)
        else $error("wrap request dropped by itself");

    property p_cmp_sticky;
        $fell(o_irq_compare[0]) |-> $past(i_wr && ((i_addr == 8'h0b && i_wdata[4])
            || (i_addr == 8'h0a && !i_wdata[4])));
    endproperty
    a_cmp_sticky: assert property (p_cmp_sticky)
        else $error("compare request dropped by itself");
endmodule // timer_regs_checker

bind timer_regs timer_regs_checker u_timer_regs_checker (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_addr(i_addr),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .i_wdata(i_wdata),
    .o_rdata(o_rdata),
    .o_irq_compare(o_irq_compare),
    .o_irq_wrap(o_irq_wrap)
);

// file: testbench/testbench.sv
// self-checking bench for the timer register block
// assumes the cpu bus model carries all register traffic
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------------
    // stimulus, checks and tests
    // ----------------------------------------------------------------------
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic tick = 1'b0;
    logic run = 1'b0;
    logic lock = 1'b0;
    logic halted = 1'b0;
    logic evt = 1'b0;
    logic dir = 1'b0;
    logic [2:0] mode = 3'b000;
    logic [7:0] addr, wdata, rdata;
    logic wr, rd, irq_wrap;
    logic [2:0] irq_cmp;
    int errors = 0;
    int compares = 0;
    logic [7:0] rst_a [7] = '{8'h07, 8'h09, 8'h0a, 8'h0b, 8'h0e, 8'h0f, 8'h10};
    logic [7:0] rst_e [7] = '{8'h00, 8'h00, 8'h00, 8'h70, 8'h00, 8'h00, 8'h00};
    logic [7:0] ev_ctl [5] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h00};
    logic [15:0] ev_exp [5] = '{16'h0014, 16'h0018, 16'h0015, 16'h000f, 16'h0019};

    // 100 MHz clock
    always #5 mclk = ~mclk;

    timer_regs u_timer_regs (
        .i_mclk(mclk), .i_nrst(nrst), .i_addr(addr), .i_wr(wr), .i_rd(rd),
        .i_wdata(wdata), .i_tick(tick), .i_run(run), .i_dir_down(dir),
        .i_waveform_mode_select(mode), .i_lock_transfer(lock),
        .i_cpu_halted(halted), .i_event(evt), .o_rdata(rdata),
        .o_irq_compare(irq_cmp), .o_irq_wrap(irq_wrap)
    );

    cpu_bus_model u_cpu_bus_model (
        .i_mclk(mclk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd),
        .o_wdata(wdata)
    );

    task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic results;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic see8(input string n, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_cpu_bus_model.rd8(a, d);
        check(n, {8'h00, d}, {8'h00, e});
    endtask

    task automatic see16(input string n, input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        u_cpu_bus_model.rd16(a, d);
        check(n, d, e);
    endtask

    task automatic w(input logic [7:0] a, input logic [7:0] d);
        u_cpu_bus_model.wr8(a, d);
    endtask

    task automatic w16(input logic [7:0] a, input logic [15:0] v);
        u_cpu_bus_model.wr16(a, v);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // tick high for n cycles, then idle long enough for the step pipeline
    task automatic ticks(input int n);
        @(posedge mclk);
        tick <= 1'b1;
        cyc(n);
        tick <= 1'b0;
        cyc(6);
    endtask

    // each event change settles past the synchroniser before anything else
    task automatic ev(input logic v);
        @(posedge mclk);
        evt <= v;
        cyc(6);
    endtask

    // a hang ends through the same closing task
    initial begin
        #200000;
        errors++;
        results;
    end

    initial begin
        cyc(10);
        nrst <= 1'b1;
        foreach (rst_a[i]) see8("reset byte", rst_a[i], rst_e[i]);
        see16("counter reset", 8'h20, 16'h0000);
        see16("period reset", 8'h26, 16'hffff);
        see8("latch after low read", 8'h0f, 8'hff);
        $display("test reset done");
        w(8'h0b, 8'h00);
        see8("flags kept", 8'h0b, 8'h70);
        w16(8'h20, 16'h0100);
        w(8'h0b, 8'h70);
        see8("flags cleared", 8'h0b, 8'h00);
        w(8'h0f, 8'ha5);
        see8("latch rw", 8'h0f, 8'ha5);
        $display("test flags done");
        w16(8'h36, 16'h0007);
        see8("period valid", 8'h07, 8'h01);
        w16(8'h3a, 16'h0055);
        w16(8'h38, 16'h0002);
        see8("compare valid", 8'h07, 8'h07);
        w(8'h07, 8'hf8);
        w(8'h07, 8'h00);
        see8("alias set", 8'h07, 8'h0f);
        $display("test buffer valid done");
        w16(8'h26, 16'h0005);
        w16(8'h20, 16'h0003);
        lock <= 1'b1;
        run <= 1'b1;
        ticks(8);
        see8("valid locked", 8'h07, 8'h0f);
        see16("period locked", 8'h26, 16'h0005);
        lock <= 1'b0;
        ticks(8);
        see8("valid cleared", 8'h07, 8'h00);
        see16("period loaded", 8'h26, 16'h0007);
        see16("compare loaded", 8'h2a, 16'h0055);
        see8("flags after wrap", 8'h0b, 8'h71);
        w(8'h0a, 8'h01);
        cyc(3);
        check("wrap request", {15'h0000, irq_wrap}, 16'h0001);
        w(8'h0b, 8'h71);
        cyc(3);
        check("wrap cleared", {15'h0000, irq_wrap}, 16'h0000);
        $display("test update done");
        w(8'h0a, 8'h10);
        see8("enable byte", 8'h0a, 8'h10);
        w16(8'h20, 16'h0002);
        cyc(3);
        check("compare request", {13'h0000, irq_cmp}, 16'h0001);
        w16(8'h20, 16'h0003);
        w(8'h0b, 8'h10);
        cyc(3);
        check("compare cleared", {13'h0000, irq_cmp}, 16'h0000);
        $display("test compare done");
        w16(8'h26, 16'h00ff);
        foreach (ev_ctl[i]) begin
            w(8'h09, ev_ctl[i]);
            w16(8'h20, 16'h0010);
            repeat (3) begin
                ev(1'b1);
                ev(1'b0);
            end
            ev(1'b1);
            ticks(5);
            ev(1'b0);
            ticks(4);
            see16("event count", 8'h20, ev_exp[i]);
        end
        $display("test events done");
        w(8'h09, 8'h00);
        w16(8'h20, 16'h0010);
        halted <= 1'b1;
        ticks(4);
        see16("halted", 8'h20, 16'h0010);
        w(8'h0e, 8'h01);
        ticks(4);
        see16("run while halted", 8'h20, 16'h0014);
        $display("test debug done");
        mode <= 3'b011;
        dir <= 1'b1;
        w16(8'h20, 16'h0001);
        ticks(2);
        see16("bottom wrap", 8'h20, 16'h00ff);
        see8("bottom flags", 8'h0b, 8'h41);
        mode <= 3'b001;
        dir <= 1'b0;
        w16(8'h20, 16'h0000);
        ticks(4);
        see16("frequency top", 8'h20, 16'h0001);
        $display("test modes done");
        results;
    end
endmodule // testbench
